// ### rtl/reclose_pkg.sv
package reclose_pkg;
	localparam int          SHOT_W          = 3;
	localparam int          SHOT_MAX        = 4;
	localparam int          NUM_SHOTS       = 5;
	localparam int          DTL_DROPOUT_CYC = 60;
	localparam int          DTL_CNT_W       = 7;
	localparam int          INTERVAL_W      = 16;
	localparam logic [2:0]  SHOT_ZERO       = 3'h0;
	localparam logic [2:0]  SHOT_ONE        = 3'h1;
	localparam logic [2:0]  DEF_LAST_SHOT   = 3'h3;
	localparam logic [6:0]  DTL_ZERO        = 7'h00;
	localparam logic [6:0]  DTL_ONE         = 7'h01;
	localparam logic [15:0] INTERVAL_ZERO   = 16'h0000;
	localparam logic [15:0] INTERVAL_ONE    = 16'h0001;

	typedef enum logic [1:0] {
		ST_RESET   = 2'b00,
		ST_CYCLE   = 2'b01,
		ST_LOCKOUT = 2'b10
	} seq_state_t;
endpackage : reclose_pkg

// ### rtl/reclose_initiate_lockout_logic.sv
// Summary of operation
// (R1) default: trip edge needs closed or cycle
// (R2) initiate edge without supervision locks out
// (R3) trip while open in interval locks out
// (R4) initiate tied zero never starts reclosing
// (R5) supervision tied zero always locks out
// (R6) supervision tied one: every edge starts
// (R7) breaker-open initiate needs trip asserted
// (R8) drive-to-lockout holds lockout and indicators
// (R9) drive-to-lockout stretched 60 cycles after drop
// (R10) drive-to-last-shot raises counter to last
// (R11) failed full sequence still reaches lockout
// (R12) skip at initiation increments shot, reloads
// (R13) skip to last shot: lockout if open
// (R14) stall holds timing start until released
// (R15) skip still processed while stalled
// (R16) stall freezes elapsed time, then resumes
// (R17) interval timing indicator output
// (R18) three intervals give last shot three
// (R19) default: no skip, stall follows trip
// (R20) shot increments per timeout, clears on reset
// (R21) one shot indicator bit per value
// (R22) edges found against previous interval
`timescale 1ns/1ns
module reclose_initiate_lockout_logic #(
	parameter int LAST_SHOT = 3
) (
	// clock and reset
	input  wire logic                                 ref_clk,
	input  wire logic                                 rstn,
	// condition inputs, asynchronous to ref_clk
	input  wire logic                                 reclose_initiate_cond,
	input  wire logic                                 initiate_supervision_cond,
	input  wire logic                                 drive_to_lockout_cond,
	input  wire logic                                 drive_to_last_shot_cond,
	input  wire logic                                 skip_shot_cond,
	input  wire logic                                 stall_interval_cond,
	input  wire logic                                 trip_cond,
	input  wire logic                                 breaker_closed_status,
	input  wire logic                                 reclose_return_cond,
	// open interval times per shot, static settings
	input  wire logic [reclose_pkg::INTERVAL_W-1:0]   interval_time_0,
	input  wire logic [reclose_pkg::INTERVAL_W-1:0]   interval_time_1,
	input  wire logic [reclose_pkg::INTERVAL_W-1:0]   interval_time_2,
	input  wire logic [reclose_pkg::INTERVAL_W-1:0]   interval_time_3,
	// status
	output logic                                      lockout_state_flag,
	output logic                                      reclose_cycle_flag,
	output logic                                      interval_timing_flag,
	output logic                                      lockout_led,
	output logic                                      close_request,
	output logic [reclose_pkg::SHOT_W-1:0]            shot_count,
	output logic [reclose_pkg::NUM_SHOTS-1:0]         shot_flags
);
	if (LAST_SHOT < 1 || LAST_SHOT > reclose_pkg::SHOT_MAX) begin : g_chk
		$error("LAST_SHOT out of range");
	end

	localparam logic [2:0] LAST = 3'(LAST_SHOT); // (R18)
	localparam int NSYNC = 9;

	// the dropout counter must hold the whole stretch without wrapping
	if ((1 << reclose_pkg::DTL_CNT_W) <= reclose_pkg::DTL_DROPOUT_CYC) begin : g_chk_dtl
		$error("dropout counter too narrow");
	end

	// the shot field must reach every indicator value
	if ((1 << reclose_pkg::SHOT_W) < reclose_pkg::NUM_SHOTS) begin : g_chk_shot
		$error("shot field too narrow");
	end

	// one indicator per shot value, zero included
	if (reclose_pkg::NUM_SHOTS != reclose_pkg::SHOT_MAX + 1) begin : g_chk_flags
		$error("shot flag count mismatch");
	end

	// two-stage synchronisers, index order matches the input list below
	logic [NSYNC-1:0] raw_in;
	logic [NSYNC-1:0] meta_ff;
	logic [NSYNC-1:0] sync_ff;
	logic [NSYNC-1:0] nxt_meta;
	logic [NSYNC-1:0] nxt_sync;

	assign raw_in = {reclose_return_cond, breaker_closed_status, trip_cond, stall_interval_cond,
		skip_shot_cond, drive_to_last_shot_cond, drive_to_lockout_cond,
		initiate_supervision_cond, reclose_initiate_cond};

	always_comb begin
		nxt_meta = raw_in;
		nxt_sync = meta_ff;
		if (!rstn) begin
			nxt_meta = '0;
			nxt_sync = '0;
		end
	end

	always_ff @(posedge ref_clk) begin
		meta_ff <= nxt_meta;
		sync_ff <= nxt_sync;
	end

	logic ri_s;
	logic ris_s;
	logic dtl_s;
	logic dls_s;
	logic skp_s;
	logic stl_s;
	logic trip_s;
	logic closed_s;
	logic ret_s;
	assign ri_s     = sync_ff[0];
	assign ris_s    = sync_ff[1];
	assign dtl_s    = sync_ff[2];
	assign dls_s    = sync_ff[3];
	assign skp_s    = sync_ff[4];
	assign stl_s    = sync_ff[5];
	assign trip_s   = sync_ff[6];
	assign closed_s = sync_ff[7];
	assign ret_s    = sync_ff[8];

	// sequencer state
	reclose_pkg::seq_state_t                state_ff;
	reclose_pkg::seq_state_t                nxt_state;
	logic                                   ri_prev_ff;
	logic                                   nxt_ri_prev;
	logic [reclose_pkg::DTL_CNT_W-1:0]      dtl_cnt_ff;
	logic [reclose_pkg::DTL_CNT_W-1:0]      nxt_dtl_cnt;
	logic [reclose_pkg::SHOT_W-1:0]         shot_ff;
	logic [reclose_pkg::SHOT_W-1:0]         nxt_shot;
	logic [reclose_pkg::INTERVAL_W-1:0]     remain_ff;
	logic [reclose_pkg::INTERVAL_W-1:0]     nxt_remain;
	logic                                   started_ff;
	logic                                   nxt_started;
	logic                                   close_ff;
	logic                                   nxt_close;
	logic                                   armed_ff;
	logic                                   nxt_armed;
	logic                                   timing_ff;
	logic                                   nxt_timing;
	logic [reclose_pkg::NUM_SHOTS-1:0]      flags_ff;
	logic [reclose_pkg::NUM_SHOTS-1:0]      nxt_flags;
	logic                                   dtl_eff;
	logic                                   ri_edge;
	logic [reclose_pkg::INTERVAL_W-1:0]     load_time;

	// previous-interval comparison gives the edge
	assign ri_edge = ri_s & ~ri_prev_ff; // (R22)
	// the stretch keeps short pulses alive long enough to overlap a breaker-open initiate
	assign dtl_eff = dtl_s | (dtl_cnt_ff != reclose_pkg::DTL_ZERO); // (R9)

	function automatic logic [reclose_pkg::INTERVAL_W-1:0] time_for(input logic [2:0] s);
		unique case (s)
			3'h0:    time_for = interval_time_0;
			3'h1:    time_for = interval_time_1;
			3'h2:    time_for = interval_time_2;
			default: time_for = interval_time_3;
		endcase
	endfunction : time_for

	always_comb begin
		logic [2:0] s;
		logic       skipped;
		s           = shot_ff;
		skipped     = 1'b0;
		nxt_state   = state_ff;
		nxt_remain  = remain_ff;
		nxt_started = started_ff;
		nxt_armed   = armed_ff;
		nxt_timing  = 1'b0;
		nxt_close   = 1'b0;
		load_time   = reclose_pkg::INTERVAL_ZERO;

		unique case (state_ff)
			reclose_pkg::ST_RESET: begin
				s = reclose_pkg::SHOT_ZERO; // (R20)
				// initiation is only the edge; inputs tied low never make one
				if (ri_edge) begin // (R4)
					if (ris_s) begin // (R1) (R6) (R7)
						nxt_state   = reclose_pkg::ST_CYCLE;
						nxt_started = 1'b0;
						nxt_armed   = 1'b1;
						if (skp_s && s < LAST) begin // (R12)
							s       = s + reclose_pkg::SHOT_ONE;
							skipped = 1'b1;
						end
						nxt_remain = time_for(s);
					end else begin
						nxt_state = reclose_pkg::ST_LOCKOUT; // (R2) (R5)
					end
				end
			end
			reclose_pkg::ST_CYCLE: begin
				if (ri_edge && !ris_s) begin
					nxt_state = reclose_pkg::ST_LOCKOUT; // (R2)
				end else if (trip_s && !closed_s && started_ff) begin
					nxt_state = reclose_pkg::ST_LOCKOUT; // (R3)
				end else if (ri_edge) begin
					// a new trip restarts the interval for the current shot
					nxt_started = 1'b0;
					nxt_armed   = 1'b1;
					if (skp_s && s < LAST) begin // (R12)
						s       = s + reclose_pkg::SHOT_ONE;
						skipped = 1'b1;
					end
					nxt_remain = time_for(s);
				end else if (armed_ff && !started_ff && skp_s && s < LAST) begin
					s          = s + reclose_pkg::SHOT_ONE; // (R15)
					skipped    = 1'b1;
					nxt_remain = time_for(s);
				end else if (armed_ff && !stl_s) begin // (R14) (R16) (R19)
					// after a reclose we wait for the next initiate, else a closed breaker would be reclosed again
					nxt_started = 1'b1;
					if (s >= LAST) begin
						nxt_state = reclose_pkg::ST_LOCKOUT; // (R11)
					end else if (remain_ff <= reclose_pkg::INTERVAL_ONE) begin
						s           = s + reclose_pkg::SHOT_ONE; // (R20)
						nxt_close   = 1'b1;
						nxt_started = 1'b0;
						nxt_armed   = 1'b0;
						load_time   = time_for(s);
						nxt_remain  = load_time;
					end else begin
						nxt_timing = 1'b1; // (R17)
						nxt_remain = remain_ff - reclose_pkg::INTERVAL_ONE;
					end
				end
				// a skip onto the last shot leaves nothing to time; open breaker means lockout
				// limited to skips so the final reclose itself is not swallowed
				if (skipped && s >= LAST && !closed_s) begin
					nxt_state = reclose_pkg::ST_LOCKOUT; // (R13)
				end
				if (ret_s && closed_s && !trip_s) begin
					nxt_state = reclose_pkg::ST_RESET;
				end
			end
			reclose_pkg::ST_LOCKOUT: begin
				if (ret_s && closed_s && !trip_s && !dtl_eff) begin
					nxt_state = reclose_pkg::ST_RESET;
				end
			end
			default: nxt_state = reclose_pkg::ST_LOCKOUT;
		endcase

		if (dtl_eff) begin
			nxt_state = reclose_pkg::ST_LOCKOUT; // (R8)
		end
		// outside the cycle state nothing times and nothing recloses
		if (nxt_state != reclose_pkg::ST_CYCLE) begin
			nxt_started = 1'b0;
			nxt_armed   = 1'b0;
			nxt_timing  = 1'b0;
			nxt_close   = 1'b0;
		end
		if ((dls_s || nxt_state == reclose_pkg::ST_LOCKOUT) && s < LAST) begin
			s = LAST; // (R10) (R18)
		end
		if (nxt_state == reclose_pkg::ST_RESET) begin
			s = reclose_pkg::SHOT_ZERO; // (R20)
		end
		nxt_shot = s;

		if (!rstn) begin
			nxt_state   = reclose_pkg::ST_RESET;
			nxt_armed   = 1'b0;
			nxt_timing  = 1'b0;
			nxt_shot    = reclose_pkg::SHOT_ZERO;
			nxt_remain  = reclose_pkg::INTERVAL_ZERO;
			nxt_started = 1'b0;
			nxt_close   = 1'b0;
		end
	end

	always_ff @(posedge ref_clk) begin
		state_ff   <= nxt_state;
		shot_ff    <= nxt_shot;
		remain_ff  <= nxt_remain;
		started_ff <= nxt_started;
		close_ff   <= nxt_close;
		armed_ff   <= nxt_armed;
		timing_ff  <= nxt_timing;
	end

	// dropout stretch group
	always_comb begin
		// reloads while asserted, then counts down to zero
		if (dtl_s) begin
			nxt_dtl_cnt = 7'(reclose_pkg::DTL_DROPOUT_CYC); // (R9)
		end else if (dtl_cnt_ff != reclose_pkg::DTL_ZERO) begin
			nxt_dtl_cnt = dtl_cnt_ff - reclose_pkg::DTL_ONE;
		end else begin
			nxt_dtl_cnt = dtl_cnt_ff;
		end
		if (!rstn) begin
			nxt_dtl_cnt = reclose_pkg::DTL_ZERO;
		end
	end

	always_ff @(posedge ref_clk) begin
		dtl_cnt_ff <= nxt_dtl_cnt;
	end

	// edge history group; cleared low so a high input after reset counts as an edge
	always_comb begin
		nxt_ri_prev = ri_s;
		if (!rstn) begin
			nxt_ri_prev = 1'b0;
		end
	end

	always_ff @(posedge ref_clk) begin
		ri_prev_ff <= nxt_ri_prev;
	end

	// shot indicators are registered beside the counter, so both change on one edge
	for (genvar i = 0; i < reclose_pkg::NUM_SHOTS; i++) begin : g_shot
		assign nxt_flags[i] = (nxt_shot == 3'(i)); // (R21)
	end

	always_ff @(posedge ref_clk) begin
		flags_ff <= nxt_flags;
	end

	assign lockout_state_flag   = (state_ff == reclose_pkg::ST_LOCKOUT); // (R8)
	assign lockout_led          = lockout_state_flag; // (R8)
	assign reclose_cycle_flag   = (state_ff == reclose_pkg::ST_CYCLE);
	// a stalled interval keeps its elapsed time but does not count as timing
	assign interval_timing_flag = timing_ff; // (R17)
	assign close_request        = close_ff;
	assign shot_count           = shot_ff;
	assign shot_flags           = flags_ff; // (R21)
endmodule : reclose_initiate_lockout_logic

// ### bench/reclose_props.sv
`timescale 1ns/1ns
module reclose_props #(
	parameter int LAST_SHOT = 3
) (
	// clock and reset
	input wire logic       ref_clk,
	input wire logic       rstn,
	// conditions
	input wire logic       drive_to_lockout_cond,
	input wire logic       stall_interval_cond,
	// status
	input wire logic       lockout_state_flag,
	input wire logic       reclose_cycle_flag,
	input wire logic       interval_timing_flag,
	input wire logic       lockout_led,
	input wire logic       close_request,
	input wire logic [2:0] shot_count,
	input wire logic [4:0] shot_flags
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rstn);
	a_flags_onehot: assert property (shot_flags == (5'h01 << shot_count)) else $error("shot flags");
	a_led_mirror: assert property (lockout_led == lockout_state_flag) else $error("lockout led");
	a_force_lock: assert property (drive_to_lockout_cond [*3] |=> lockout_state_flag) else $error("no lockout");
	a_lock_shot: assert property (lockout_state_flag [*3] |-> shot_count == 3'(LAST_SHOT)) else $error("shot");
	a_timing_cycle: assert property (interval_timing_flag |-> $past(reclose_cycle_flag)) else $error("timing");
	a_close_pulse: assert property (close_request |=> !close_request) else $error("close width");
	a_close_shot: assert property (close_request |-> shot_count == $past(shot_count) + 3'h1) else $error("inc");
	a_stall_hold: assert property (stall_interval_cond [*3] |=> !interval_timing_flag) else $error("stall");
	a_one_state: assert property (!(lockout_state_flag && reclose_cycle_flag)) else $error("two states");
	c_close: cover property (close_request);
	c_lock: cover property ($rose(lockout_state_flag));
	c_timing: cover property (interval_timing_flag);
endmodule : reclose_props
bind reclose_initiate_lockout_logic reclose_props #(.LAST_SHOT(LAST_SHOT)) u_props (.ref_clk, .rstn,
	.drive_to_lockout_cond, .stall_interval_cond, .lockout_state_flag, .reclose_cycle_flag,
	.interval_timing_flag, .lockout_led, .close_request, .shot_count, .shot_flags);

// ### bench/breaker_model.sv
`timescale 1ns/1ns
module breaker_model (
	// commands
	input  wire logic ref_clk,
	input  wire logic trip_req,
	input  wire logic open_cmd,
	input  wire logic close_cmd,
	// contacts
	output logic      trip_cond,
	output logic      breaker_closed_status
);
	logic closed_ff;
	logic nxt_closed;
	// contacts lag the command by a cycle, so a trip edge still sees the breaker closed
	assign trip_cond = trip_req;
	assign breaker_closed_status = closed_ff;
	always_comb begin
		nxt_closed = closed_ff;
		if (trip_req || open_cmd) nxt_closed = 1'b0;
		else if (close_cmd) nxt_closed = 1'b1;
	end
	initial closed_ff = 1'b1;
	always @(posedge ref_clk) begin
		closed_ff <= nxt_closed;
	end
endmodule : breaker_model

// ### bench/tb.sv
`timescale 1ns/1ns
module tb;
	logic       ref_clk, rstn, trip_req, op_cmd, cl_cmd, dtl, ret, alt, skp;
	logic       trip_cond, brk, lock, cyc, tim, led, clr;
	logic [2:0] shot;
	logic [4:0] flags;
	int         err_total, tests_run;
	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end
	breaker_model u_brk (.ref_clk, .trip_req, .open_cmd(op_cmd), .close_cmd(cl_cmd | clr), .trip_cond,
		.breaker_closed_status(brk));
	// alt selects initiate on breaker opening, supervised by trip
	reclose_initiate_lockout_logic u_dut (.ref_clk, .rstn, .reclose_initiate_cond(alt ? !brk : trip_cond),
		.initiate_supervision_cond(alt ? trip_cond : (brk | cyc)), .drive_to_lockout_cond(dtl),
		.drive_to_last_shot_cond(lock), .skip_shot_cond(skp), .stall_interval_cond(trip_cond), .trip_cond,
		.breaker_closed_status(brk), .reclose_return_cond(ret), .interval_time_0(16'h0014),
		.interval_time_1(16'h0014), .interval_time_2(16'h0014), .interval_time_3(16'h0014),
		.lockout_state_flag(lock), .reclose_cycle_flag(cyc), .interval_timing_flag(tim), .lockout_led(led),
		.close_request(clr), .shot_count(shot), .shot_flags(flags));
	task results;
		$display("checks %0d errors %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : results
	task chk(input string nm, input logic [4:0] exp, input logic [4:0] got);
		tests_run++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] %s exp %h got %h", nm, exp, got);
		end
	endtask : chk
	task tick(input int n);
		repeat (n) @(posedge ref_clk);
	endtask : tick
	task wt(input int s, input int n);
		int i;
		i = 0;
		while (((s == 0) ? clr : (s == 1) ? tim : !lock) !== 1'b1) begin
			i++;
			if (i > n) begin
				chk("wait", 5'h00, 5'h1F);
				results();
			end
			@(posedge ref_clk);
		end
	endtask : wt
	initial begin
		{rstn, trip_req, op_cmd, cl_cmd, dtl, ret, alt, skp} = 8'h00;
		err_total = 0;
		tests_run = 0;
		tick(5);
		rstn <= 1'b1;
		tick(2);
		chk("flags", 5'h01, flags);
		chk("status", 5'h00, {lock, cyc, tim, led, clr});
		trip_req <= 1'b1;
		tick(6);
		chk("cycle", 5'h01, cyc);
		chk("stalled", 5'h00, tim);
		trip_req <= 1'b0;
		wt(0, 60);
		chk("shot", 5'h01, shot);
		chk("flags", 5'h02, flags);
		tick(4);
		trip_req <= 1'b1;
		tick(4);
		trip_req <= 1'b0;
		wt(1, 20);
		trip_req <= 1'b1;
		tick(8);
		chk("lockout", 5'h01, lock);
		chk("last shot", 5'h03, shot);
		trip_req <= 1'b0;
		cl_cmd <= 1'b1;
		ret <= 1'b1;
		tick(1);
		cl_cmd <= 1'b0;
		tick(8);
		chk("reset flags", 5'h01, flags);
		chk("reset state", 5'h00, {lock, cyc});
		dtl <= 1'b1;
		tick(3);
		dtl <= 1'b0;
		tick(4);
		chk("led", 5'h01, led);
		tick(40);
		chk("stretch", 5'h01, lock);
		wt(2, 40);
		ret <= 1'b0;
		alt <= 1'b1;
		tick(4);
		op_cmd <= 1'b1;
		tick(1);
		op_cmd <= 1'b0;
		tick(6);
		chk("open no trip", 5'h01, lock);
		cl_cmd <= 1'b1;
		ret <= 1'b1;
		alt <= 1'b0;
		skp <= 1'b1;
		tick(1);
		cl_cmd <= 1'b0;
		wt(2, 20);
		ret <= 1'b0;
		trip_req <= 1'b1;
		tick(6);
		chk("skip lockout", 5'h01, lock);
		chk("skip shot", 5'h03, shot);
		results();
	end
endmodule : tb
